// File: hdl/psp_defs.svh
// constants for the power stage protection controller
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

`define PSP_CLK_MHZ          100
`define PSP_CHARGE_US        800
`define PSP_HOLD_US          1000
`define PSP_HOLD_CYC         (`PSP_HOLD_US * `PSP_CLK_MHZ)
`define PSP_RECOVER_LOW_US   10
`define PSP_RECOVER_LOW_CYC  (`PSP_RECOVER_LOW_US * `PSP_CLK_MHZ)
`define PSP_STOP_GAP_US      10
`define PSP_STOP_GAP_CYC     (`PSP_STOP_GAP_US * `PSP_CLK_MHZ)
`define PSP_PWM_KHZ          375
`define PSP_PWM_PERIOD       (`PSP_CLK_MHZ * 1000 / `PSP_PWM_KHZ)
`define PSP_RECOVER_N        512
`define PSP_DUTY_W           9

`define PSP_REG_CTRL         4'h0
`define PSP_REG_DUTY         4'h4
`define PSP_REG_STATUS       4'h8

`define PSP_CTRL_ON          0
`define PSP_CTRL_MUTE        1
`define PSP_CTRL_RECOVER     2
`define PSP_DUTY_RESET       9'h085

`define PSP_ST_FAULT         0
`define PSP_ST_WARN          1
`define PSP_ST_RST           2
`define PSP_ST_PWM           3
`define PSP_ST_SEQ           4

`endif

// File: hdl/psp_pkg.sv
// types shared by both ends of the power stage link
package psp_pkg;
    typedef enum logic [1:0] {
        psp_recover_mode   = 2'h0,
        psp_latch_off_mode = 2'h1,
        psp_no_protect_mode = 2'h2,
        psp_reserved_mode  = 2'h3
    } psp_mode_t;

    typedef enum logic [4:0] {
        psp_seq_off     = 5'h01,
        psp_seq_charge  = 5'h02,
        psp_seq_run     = 5'h04,
        psp_seq_recover = 5'h08,
        psp_seq_stop    = 5'h10
    } psp_seq_t;
endpackage

// File: hdl/psp_link_if.sv
// link between controller and power stage, with open-drain status pins
`timescale 1ns/1ps
interface psp_link_if #(parameter int CH = 2);
    logic          reset_n;
    logic [CH-1:0] modulated_input;
    logic          fault_o;
    logic          fault_oe_n;
    logic          warn_o;
    logic          warn_oe_n;
    logic          fault_flag_n;
    logic          overtemp_warning_n;

    // pull-up wins whenever the driver is off
    assign fault_flag_n       = fault_oe_n ? 1'b1 : fault_o;
    assign overtemp_warning_n = warn_oe_n ? 1'b1 : warn_o;

    modport device (
        input  reset_n,
        input  modulated_input,
        output fault_o,
        output fault_oe_n,
        output warn_o,
        output warn_oe_n
    );

    modport ctrl (
        output reset_n,
        output modulated_input,
        input  fault_flag_n,
        input  overtemp_warning_n
    );
endinterface

// File: hdl/psp_pwm_gen.sv
// switching pulse generator used by the controller
`timescale 1ns/1ps
`include "psp_defs.svh"
module psp_pwm_gen #(
    parameter int CH     = 2,
    parameter int PERIOD = `PSP_PWM_PERIOD
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   run,
    input  wire logic [`PSP_DUTY_W-1:0] duty,
    output logic      [CH-1:0]          pulse
);
    localparam int CW = $clog2(PERIOD);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [CH-1:0] pulse;
    } psp_pwm_state_t;

    psp_pwm_state_t        s;
    psp_pwm_state_t        next_s;
    logic [`PSP_DUTY_W-1:0] duty_eff;
    logic [CH-1:0]          next_pulse;

    // never 0 % or 100 %: a steady high would starve the bootstrap cap
    assign duty_eff = (duty == '0) ? `PSP_DUTY_W'(1) :
                      (duty >= `PSP_DUTY_W'(PERIOD)) ? `PSP_DUTY_W'(PERIOD - 1) : duty;

    genvar i;
    generate
        for (i = 0; i < CH; i++) begin : g_ch
            assign next_pulse[i] = run && (`PSP_DUTY_W'(s.cnt) < duty_eff);
        end
    endgenerate

    always_comb begin
        next_s = s;
        next_s.pulse = next_pulse;
        if (!run || s.cnt == CW'(PERIOD - 1)) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pulse = s.pulse;
endmodule

// File: hdl/psp_controller.sv
// modulator front end and system controller with an ahb-lite register port
`timescale 1ns/1ps
`include "psp_defs.svh"
module psp_controller #(
    parameter int CH             = 2,
    parameter int HOLD_CYCLES    = `PSP_HOLD_CYC,
    parameter int RECOVER_CYCLES = `PSP_RECOVER_LOW_CYC,
    parameter int STOP_CYCLES    = `PSP_STOP_GAP_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    psp_link_if.ctrl         link,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);
    localparam int TW = $clog2(HOLD_CYCLES + 1);

    typedef struct packed {
        psp_pkg::psp_seq_t      seq;
        logic [TW-1:0]          timer;
        logic                   on;
        logic                   mute;
        logic                   recover_req;
        logic [`PSP_DUTY_W-1:0] duty;
        logic                   rst_out;
        logic                   pwm_run;
        logic                   ap_write;
        logic [3:0]             ap_addr;
        logic [31:0]            rdata;
    } psp_ctrl_state_t;

    psp_ctrl_state_t s;
    psp_ctrl_state_t next_s;
    logic            ap_take;
    logic [31:0]     status;

    assign ap_take = hsel && htrans[1] && hready;

    always_comb begin
        next_s = s;
        next_s.ap_write = ap_take && hwrite;
        next_s.ap_addr  = ap_take ? haddr[3:0] : 4'h0;
        if (s.ap_write) begin
            if (s.ap_addr == `PSP_REG_CTRL) begin
                next_s.on   = hwdata[`PSP_CTRL_ON];
                next_s.mute = hwdata[`PSP_CTRL_MUTE];
                if (hwdata[`PSP_CTRL_RECOVER]) begin
                    next_s.recover_req = 1'b1;
                end
            end else if (s.ap_addr == `PSP_REG_DUTY) begin
                next_s.duty = hwdata[`PSP_DUTY_W-1:0];
            end
        end
        next_s.timer = s.timer + TW'(1);
        case (s.seq)
            psp_pkg::psp_seq_off: begin
                next_s.rst_out = 1'b0;
                next_s.pwm_run = 1'b0;
                next_s.recover_req = 1'b0;
                if (s.on) begin
                    next_s.seq     = psp_pkg::psp_seq_charge;
                    next_s.pwm_run = 1'b1;
                    next_s.timer   = '0;
                end
            end
            psp_pkg::psp_seq_charge: begin
                if (!s.on) begin
                    next_s.seq   = psp_pkg::psp_seq_stop;
                    next_s.timer = '0;
                end else if (s.timer == TW'(HOLD_CYCLES - 1)) begin
                    next_s.seq     = psp_pkg::psp_seq_run;
                    next_s.rst_out = 1'b1;
                end
            end
            psp_pkg::psp_seq_run: begin
                next_s.rst_out = !s.mute;
                if (!s.on) begin
                    next_s.seq     = psp_pkg::psp_seq_stop;
                    next_s.rst_out = 1'b0;
                    next_s.timer   = '0;
                end else if (s.recover_req) begin
                    next_s.seq         = psp_pkg::psp_seq_recover;
                    next_s.rst_out     = 1'b0;
                    next_s.recover_req = 1'b0;
                    next_s.timer       = '0;
                end
            end
            psp_pkg::psp_seq_recover: begin
                if (s.timer == TW'(RECOVER_CYCLES - 1)) begin
                    next_s.seq     = psp_pkg::psp_seq_run;
                    next_s.rst_out = !s.mute;
                end
            end
            psp_pkg::psp_seq_stop: begin
                // pulses keep running until the stage has been reset
                next_s.rst_out = 1'b0;
                if (s.timer == TW'(STOP_CYCLES - 1)) begin
                    next_s.seq     = psp_pkg::psp_seq_off;
                    next_s.pwm_run = 1'b0;
                end
            end
            default: begin
                next_s.seq     = psp_pkg::psp_seq_off;
                next_s.rst_out = 1'b0;
                next_s.pwm_run = 1'b0;
            end
        endcase
        status = 32'h0;
        status[`PSP_ST_FAULT] = !link.fault_flag_n;
        status[`PSP_ST_WARN]  = !link.overtemp_warning_n;
        status[`PSP_ST_RST]   = s.rst_out;
        status[`PSP_ST_PWM]   = s.pwm_run;
        status[`PSP_ST_SEQ +: 5] = s.seq;
        next_s.rdata = 32'h0;
        if (ap_take && !hwrite) begin
            case (haddr[3:0])
                `PSP_REG_CTRL: begin
                    next_s.rdata[`PSP_CTRL_ON]      = next_s.on;
                    next_s.rdata[`PSP_CTRL_MUTE]    = next_s.mute;
                    next_s.rdata[`PSP_CTRL_RECOVER] = next_s.recover_req;
                end
                `PSP_REG_DUTY:   next_s.rdata[`PSP_DUTY_W-1:0] = next_s.duty;
                `PSP_REG_STATUS: next_s.rdata = status;
                default:         next_s.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s      <= '0;
            s.seq  <= psp_pkg::psp_seq_off;
            s.duty <= `PSP_DUTY_RESET;
        end else begin
            s <= next_s;
        end
    end

    psp_pwm_gen #(
        .CH     (CH),
        .PERIOD (`PSP_PWM_PERIOD)
    ) u_pwm (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (s.pwm_run),
        .duty    (s.duty),
        .pulse   (link.modulated_input)
    );

    assign link.reset_n = s.rst_out;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = s.rdata;
endmodule

// File: hdl/psp_power_stage.sv
// protection and output-gating logic of the stereo switching power stage
`timescale 1ns/1ps
`include "psp_defs.svh"
//
// Function
// - reset low keeps every switch off
// - controller holds reset low past bootstrap charge
// - valid pulses run before reset release
// - modulator never drives a steady high
// - front end initialised before reset release
// - at power-down reset falls before pulses stop
// - power-up always starts in hi-z
// - fault pin low while error present
// - fault pin released while reset low
// - warning pin low above warning temperature
// - pin pair encodes temperature, current, normal
// - every protection event forces hi-z
// - reset pulse low-high recovers after errors
// - overcurrent watched on every switch
// - one temperature detector for both channels
// - shared undervoltage lockout on gate supply
// - reset low mutes the output stage
// - latch clears on reset fall, resumes high
// - self-recovery resumes without controller reset
// - recovery timed by shared pulse count
// - latch clears at n/2, resume at n
// - straps select recover, latch, none, reserved
// - separate thermal error at higher temperature
module psp_power_stage #(
    parameter int CH        = 2,
    parameter int RECOVER_N = `PSP_RECOVER_N
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    psp_link_if.device         link,
    input  wire logic [CH-1:0] oc_high_trip,
    input  wire logic [CH-1:0] oc_low_trip,
    input  wire logic          temp_warn_level,
    input  wire logic          thermal_error,
    input  wire logic          supply_lockout,
    input  wire logic          prot_select_a,
    input  wire logic          prot_select_b,
    output logic      [CH-1:0] high_side_on,
    output logic      [CH-1:0] low_side_on,
    output logic               output_hiz,
    output logic               error_latched,
    output logic               self_recovery,
    output psp_pkg::psp_mode_t prot_mode
);
    localparam int CW = $clog2(RECOVER_N);

    typedef struct packed {
        logic               mode_valid;
        psp_pkg::psp_mode_t mode;
        logic               pwm_q;
        logic               latch;
        logic               thermal_latched;
        logic               current_latched;
        logic               hold;
        logic [CW-1:0]      cnt;
        logic [CH-1:0]      hi;
        logic [CH-1:0]      lo;
        logic               hiz;
        logic               fault_drv;
        logic               warn_drv;
    } psp_dev_state_t;

    psp_dev_state_t s;
    psp_dev_state_t next_s;
    logic           overcurrent_fault;
    logic           current_err;
    logic           any_err;
    logic           prot_on;
    logic           pwm_rise;
    logic           hiz_now;
    logic [CH-1:0]  next_hi;
    logic [CH-1:0]  next_lo;

    assign overcurrent_fault = (|oc_high_trip) || (|oc_low_trip);
    assign current_err = overcurrent_fault || supply_lockout;
    // one thermal input serves both bridges
    assign any_err = current_err || thermal_error;
    assign prot_on = s.mode_valid && (s.mode != psp_pkg::psp_no_protect_mode);
    // channel 0 paces the shared timer; all channels switch at one rate
    assign pwm_rise = link.modulated_input[0] && !s.pwm_q;

    // reset low is a mute as well as the hi-z state of power-up
    assign hiz_now = !link.reset_n || !s.mode_valid || s.latch || s.hold;

    genvar i;
    generate
        for (i = 0; i < CH; i++) begin : g_bridge
            assign next_hi[i] = !hiz_now && link.modulated_input[i];
            assign next_lo[i] = !hiz_now && !link.modulated_input[i];
        end
    endgenerate

    always_comb begin
        next_s = s;
        next_s.pwm_q = link.modulated_input[0];
        if (!s.mode_valid) begin
            // straps are caught once, on the first edge after release
            next_s.mode_valid = 1'b1;
            next_s.mode = psp_pkg::psp_mode_t'({prot_select_a, prot_select_b});
        end
        if (!link.reset_n) begin
            next_s.latch           = 1'b0;
            next_s.thermal_latched = 1'b0;
            next_s.current_latched = 1'b0;
            next_s.hold            = 1'b0;
            next_s.cnt             = '0;
        end else begin
            if (s.mode == psp_pkg::psp_recover_mode && s.hold && pwm_rise) begin
                if (s.cnt == CW'(RECOVER_N / 2 - 1)) begin
                    next_s.latch           = 1'b0;
                    next_s.thermal_latched = 1'b0;
                    next_s.current_latched = 1'b0;
                end
                if (s.cnt == CW'(RECOVER_N - 1)) begin
                    next_s.hold = 1'b0;
                    next_s.cnt  = '0;
                end else begin
                    next_s.cnt = s.cnt + CW'(1);
                end
            end
            // set after the clear so a fresh error is never lost
            if (prot_on && any_err) begin
                next_s.latch           = 1'b1;
                next_s.hold            = 1'b1;
                next_s.thermal_latched = s.thermal_latched || thermal_error;
                next_s.current_latched = s.current_latched || current_err;
                if (!s.latch) begin
                    next_s.cnt = '0;
                end
            end
        end
        next_s.hiz = hiz_now;
        next_s.hi  = next_hi;
        next_s.lo  = next_lo;
        // reset low always releases the fault pin, whatever is latched
        next_s.fault_drv = link.reset_n && next_s.latch;
        // warning low for warning or error: both low reads as thermal error
        next_s.warn_drv = temp_warn_level || thermal_error || next_s.thermal_latched;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s     <= '0;
            s.hiz <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // open drain: only ever pull low
    assign link.fault_o    = 1'b0;
    assign link.fault_oe_n = !s.fault_drv;
    assign link.warn_o     = 1'b0;
    assign link.warn_oe_n  = !s.warn_drv;

    assign high_side_on  = s.hi;
    assign low_side_on   = s.lo;
    assign output_hiz    = s.hiz;
    assign error_latched = s.latch;
    assign self_recovery = s.hold && (s.mode == psp_pkg::psp_recover_mode);
    assign prot_mode     = s.mode;
endmodule

// File: test/psp_link_sva.sv
// assertions on the link between controller and power stage
`timescale 1ns/1ps
module psp_link_sva #(
    parameter int CH = 2
) (
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          reset_n,
    input wire logic [CH-1:0] modulated_input,
    input wire logic          fault_o,
    input wire logic          fault_oe_n,
    input wire logic          warn_o,
    input wire logic          warn_oe_n,
    input wire logic          fault_flag_n,
    input wire logic          overtemp_warning_n
);
    // no legal pulse level outlasts one 266-cycle period
    localparam int PULSE_MAX = 266;
    logic       prev;
    logic       ran;
    logic [9:0] quiet_cnt;
    logic [9:0] hi_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev      <= 1'b0;
            ran       <= 1'b0;
            quiet_cnt <= 10'h0;
            hi_cnt    <= 10'h0;
        end else begin
            prev      <= modulated_input[0];
            ran       <= (modulated_input[0] != prev) || (ran && quiet_cnt < 10'(PULSE_MAX));
            quiet_cnt <= (modulated_input[0] != prev) ? 10'h0
                         : quiet_cnt + 10'(quiet_cnt != 10'h3ff);
            hi_cnt    <= modulated_input[0] ? hi_cnt + 10'(hi_cnt != 10'h3ff) : 10'h0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_held_low;
        !reset_n [*8];
    endsequence
    sequence s_still_off;
        (!reset_n && fault_flag_n) ##1 !reset_n;
    endsequence

    AST_FAULT_DRIVE_LOW: assert property (fault_o == 1'b0)
        else $error("fault pin driven high");
    AST_WARN_DRIVE_LOW: assert property (warn_o == 1'b0)
        else $error("warning pin driven high");
    AST_FAULT_RELEASE_IN_RESET: assert property (!reset_n [*3] |-> fault_oe_n)
        else $error("fault pin low while stage in reset");
    AST_POWERUP_HELD_LOW: assert property ($rose(hresetn) |-> s_still_off)
        else $error("stage not held off at power-up");
    AST_PULSES_BEFORE_RELEASE: assert property ($rose(reset_n) |-> ran)
        else $error("reset released without pulses");
    AST_RESET_BEFORE_STOP: assert property (quiet_cnt > 10'(PULSE_MAX) |-> !reset_n)
        else $error("pulses stopped while stage enabled");
    AST_NO_STEADY_HIGH: assert property (hi_cnt < 10'(PULSE_MAX))
        else $error("pulse line held high");
    AST_RECOVER_PULSE: assert property ($fell(reset_n) |-> s_held_low)
        else $error("reset pulse too short");
endmodule

// File: test/power_stage_protection_ctrl_tb_top.sv
// bench joining controller and power stage, driven over ahb-lite
`timescale 1ns/1ps
module power_stage_protection_ctrl_tb_top;
    localparam int HOLD = 200;
    localparam int RECN = 8;
    logic               hclk = 1'b0;
    logic               hresetn = 1'b0;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = 32'h0;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'b0;
    logic [2:0]         hsize = 3'h0;
    logic [31:0]        hwdata = 32'h0;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    logic [1:0]         oc_high_trip = 2'h0;
    logic [1:0]         oc_low_trip = 2'h0;
    logic               temp_warn_level = 1'b0;
    logic               thermal_error = 1'b0;
    logic               supply_lockout = 1'b0;
    logic               prot_select_a = 1'b0;
    logic               prot_select_b = 1'b0;
    logic [1:0]         high_side_on;
    logic [1:0]         low_side_on;
    logic               output_hiz;
    logic               error_latched;
    logic               self_recovery;
    psp_pkg::psp_mode_t prot_mode;
    logic [31:0]        rd;
    int                 n_mismatch = 0;
    int                 samples_checked = 0;
    int                 cycles = 0;

    psp_link_if #(.CH(2)) link ();

    psp_controller #(.HOLD_CYCLES(HOLD), .RECOVER_CYCLES(20), .STOP_CYCLES(20))
    u_psp_controller (
        .hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    psp_power_stage #(.CH(2), .RECOVER_N(RECN)) u_psp_power_stage (
        .hclk(hclk), .hresetn(hresetn), .link(link), .oc_high_trip(oc_high_trip),
        .oc_low_trip(oc_low_trip), .temp_warn_level(temp_warn_level),
        .thermal_error(thermal_error), .supply_lockout(supply_lockout),
        .prot_select_a(prot_select_a), .prot_select_b(prot_select_b),
        .high_side_on(high_side_on), .low_side_on(low_side_on), .output_hiz(output_hiz),
        .error_latched(error_latched), .self_recovery(self_recovery), .prot_mode(prot_mode));

    psp_link_sva u_psp_link_sva (
        .hclk(hclk), .hresetn(hresetn), .reset_n(link.reset_n),
        .modulated_input(link.modulated_input), .fault_o(link.fault_o),
        .fault_oe_n(link.fault_oe_n), .warn_o(link.warn_o), .warn_oe_n(link.warn_oe_n),
        .fault_flag_n(link.fault_flag_n), .overtemp_warning_n(link.overtemp_warning_n));

    always #5 hclk = ~hclk;

    task automatic end_sim();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // the whole run needs about 16k cycles
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // entered just after a rising edge, returns at the edge that ends the data phase
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic boot(input logic [1:0] mode);
        int t;
        logic [1:0] p;
        hresetn <= 1'b0;
        prot_select_a <= mode[1];
        prot_select_b <= mode[0];
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        check(32'(prot_mode), 32'(mode), "mode");
        check(32'({output_hiz, high_side_on, low_side_on}), 32'h10, "hiz at start");
        ahb(1'b1, 32'h0, 32'h1);
        t = 0;
        while (link.reset_n !== 1'b1) begin
            @(posedge hclk);
            t++;
        end
        check(32'(t >= HOLD - 2), 32'h1, "hold");
        repeat (3) @(posedge hclk);
        p = link.modulated_input;
        @(posedge hclk);
        check(32'({output_hiz, high_side_on}), 32'(p), "switching");
    endtask

    task automatic count_to(input logic on_fault, inout int n);
        logic prev;
        prev = link.modulated_input[0];
        while (on_fault ? (link.fault_flag_n !== 1'b1) : (self_recovery !== 1'b0)) begin
            @(posedge hclk);
            if (link.modulated_input[0] === 1'b1 && prev === 1'b0) n++;
            prev = link.modulated_input[0];
        end
    endtask

    initial begin
        int n;
        boot(2'h0);
        for (int k = 0; k < 4; k++) begin
            // start from a fresh pulse rise so none falls inside the error window
            @(posedge link.modulated_input[0]);
            // keep clear of the pulse edge that was just counted
            repeat (5) @(posedge hclk);
            if (k == 0) oc_high_trip <= 2'h2;
            if (k == 1) oc_low_trip <= 2'h1;
            if (k == 2) supply_lockout <= 1'b1;
            if (k == 3) thermal_error <= 1'b1;
            @(posedge hclk);
            {oc_high_trip, oc_low_trip, supply_lockout, thermal_error} <= 6'h0;
            repeat (2) @(posedge hclk);
            check(32'({link.overtemp_warning_n, link.fault_flag_n}), (k == 3) ? 32'h0 : 32'h2,
                  "pin pair");
            check(32'({output_hiz, error_latched, high_side_on, low_side_on}), 32'h30,
                  "hiz on error");
            n = 0;
            count_to(1'b1, n);
            check(32'(n), 32'(RECN / 2), "edges to clear");
            check(32'(output_hiz), 32'h1, "hiz after clear");
            count_to(1'b0, n);
            check(32'(n), 32'(RECN), "edges to resume");
            repeat (2) @(posedge hclk);
            check(32'(output_hiz), 32'h0, "resumed");
        end
        temp_warn_level <= 1'b1;
        repeat (3) @(posedge hclk);
        check(32'({link.overtemp_warning_n, link.fault_flag_n, output_hiz}), 32'h2,
              "warning");
        temp_warn_level <= 1'b0;
        repeat (3) @(posedge hclk);
        check(32'({link.overtemp_warning_n, link.fault_flag_n}), 32'h3, "normal");
        for (int m = 1; m < 4; m += 2) begin
            boot(2'(m));
            oc_low_trip <= 2'h2;
            @(posedge hclk);
            oc_low_trip <= 2'h0;
            repeat (RECN * 300) @(posedge hclk);
            check(32'({link.fault_flag_n, output_hiz}), 32'h1, "latched");
            ahb(1'b1, 32'h0, 32'h5);
            while (link.reset_n !== 1'b0) @(posedge hclk);
            repeat (3) @(posedge hclk);
            check(32'({link.fault_flag_n, output_hiz}), 32'h3, "reset clears");
            while (link.reset_n !== 1'b1) @(posedge hclk);
            repeat (3) @(posedge hclk);
            check(32'({link.fault_flag_n, output_hiz}), 32'h2, "recovered");
        end
        boot(2'h2);
        thermal_error <= 1'b1;
        oc_high_trip <= 2'h1;
        repeat (3) @(posedge hclk);
        check(32'({link.overtemp_warning_n, link.fault_flag_n, output_hiz, error_latched}),
              32'h4, "unprotected");
        thermal_error <= 1'b0;
        oc_high_trip <= 2'h0;
        repeat (3) @(posedge hclk);
        ahb(1'b0, 32'h8, 32'h0);
        check(rd, 32'h4c, "status");
        check(32'(hresp), 32'h0, "okay response");
        ahb(1'b0, 32'h4, 32'h0);
        check(rd, 32'h85, "duty reset");
        ahb(1'b1, 32'h4, 32'h100);
        ahb(1'b0, 32'h4, 32'h0);
        check(rd, 32'h100, "duty");
        ahb(1'b1, 32'hc, 32'hffffffff);
        ahb(1'b0, 32'hc, 32'h0);
        check(rd, 32'h0, "unmapped");
        ahb(1'b1, 32'h0, 32'h3);
        repeat (10) @(posedge hclk);
        check(32'({link.reset_n, output_hiz}), 32'h1, "mute");
        ahb(1'b1, 32'h0, 32'h1);
        while (link.reset_n !== 1'b1) @(posedge hclk);
        repeat (3) @(posedge hclk);
        check(32'(output_hiz), 32'h0, "unmute");
        ahb(1'b1, 32'h0, 32'h0);
        repeat (3) @(posedge hclk);
        check(32'({link.reset_n, output_hiz}), 32'h1, "power down");
        repeat (600) @(posedge hclk);
        end_sim();
    end
endmodule
